/* File: hdl/core_clock_ratio_decoder.v */
/*
 * Core clock ratio decoder: captures the four strap pins at reset
 * release and presents the selected clock mode as registered outputs.
 * Assumes straps are synchronous to ref_clk and stable during reset.
 */
// Function
// - Code 0100: core 2x bus, loop 2x
// - Code 0101: core 2x bus, loop 4x
// - Code 0110: core 2.5x bus, loop 2x
// - Code 1000: core 3x bus, loop 2x
// - Code 1110: core 3.5x bus, loop 2x
// - Code 1010: core 4x bus, loop 2x
// - Code 0111: core 4.5x bus, loop 2x
// - Code 1011: core 5x bus, loop 2x
// - Code 1001: core 5.5x bus, loop 2x
// - Code 1101: core 6x bus, loop 2x
// - Code 0011: loop off, core from bus, 1:1
// - Code 1111: no internal clocking at all
// - Frequencies follow only from the code
`timescale 1ns/100ps
`include "core_clock_ratio_regs.vh"

module core_clock_ratio_decoder (
    input wire ref_clk,
    input wire rst_b,
    input wire [0:3] ratioSelect,
    output reg [3:0] coreMultHalf,
    output reg [2:0] vcoMult,
    output reg loopEnable,
    output reg coreClockEnable,
    output reg bypassOneToOne,
    output reg reservedCode,
    output reg configValid
);

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Taken once on the first edge after release, since an async
    // reset may only load constants.
    reg captured;
    reg [3:0] strapCode;
    wire [3:0] codeMsbFirst;

    assign codeMsbFirst = {ratioSelect[0], ratioSelect[1],
                           ratioSelect[2], ratioSelect[3]};

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            captured <= 1'b0;
            strapCode <= `CFG_CLK_OFF;
        end else if (!captured) begin
            captured <= 1'b1;
            strapCode <= codeMsbFirst;
        end
    end

    // ----------------------------------------------------------------
    // Multiplier lookup
    // ----------------------------------------------------------------
    wire [3:0] lookHalf;
    wire [2:0] lookVco;

    // Mode flags are decoded below, one arm per code; only multipliers used
    ratio_code_lookup lookup (
        .code(strapCode),
        .coreHalf(lookHalf),
        .vcoMult(lookVco),
        .mode()
    );

    // ----------------------------------------------------------------
    // Mode flags per code
    // ----------------------------------------------------------------
    // Spelled out per code rather than grouped, so each code's clocking
    // can be held against the board's strap table line by line.
    reg codeLoop;
    reg codeCore;
    reg codeBypass;
    reg codeReserved;

    always @* begin
        codeLoop = 1'b0;
        codeCore = 1'b0;
        codeBypass = 1'b0;
        codeReserved = 1'b0;
        case (strapCode)
            `CFG_2X_VCO2: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_2X_VCO4: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_2P5X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_3X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_3P5X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_4X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_4P5X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_5X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_5P5X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_6X: begin
                codeLoop = 1'b1;
                codeCore = 1'b1;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            `CFG_BYPASS: begin
                codeLoop = 1'b0;
                codeCore = 1'b1;
                codeBypass = 1'b1;
                codeReserved = 1'b0;
            end

            `CFG_CLK_OFF: begin
                codeLoop = 1'b0;
                codeCore = 1'b0;
                codeBypass = 1'b0;
                codeReserved = 1'b0;
            end

            default: begin
                // Undefined codes stay dark, flag raised for board logic
                codeLoop = 1'b0;
                codeCore = 1'b0;
                codeBypass = 1'b0;
                codeReserved = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Claim gate
    // ----------------------------------------------------------------
    // Nothing is claimed before the strap is held
    wire [3:0] next_coreMultHalf;
    wire [2:0] next_vcoMult;
    wire next_loopEnable;
    wire next_coreClockEnable;
    wire next_bypassOneToOne;
    wire next_reservedCode;

    assign next_coreMultHalf = captured ? lookHalf : 4'h0;
    assign next_vcoMult = captured ? lookVco : `VCO_NONE;
    assign next_loopEnable = codeLoop && captured;
    assign next_coreClockEnable = codeCore && captured;
    assign next_bypassOneToOne = codeBypass && captured;
    assign next_reservedCode = codeReserved && captured;

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            coreMultHalf <= 4'h0;
            vcoMult <= `VCO_NONE;
            loopEnable <= 1'b0;
            coreClockEnable <= 1'b0;
            bypassOneToOne <= 1'b0;
            reservedCode <= 1'b0;
            configValid <= 1'b0;
        end else begin
            coreMultHalf <= next_coreMultHalf;
            vcoMult <= next_vcoMult;
            loopEnable <= next_loopEnable;
            coreClockEnable <= next_coreClockEnable;
            bypassOneToOne <= next_bypassOneToOne;
            reservedCode <= next_reservedCode;
            configValid <= captured;
        end
    end

endmodule

/* File: hdl/core_clock_ratio_regs.vh */
/*
 * Constants for the core clock ratio decoder: configuration codes,
 * core multiplier encodings (in half steps), loop multiplier encodings and mode codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CORE_CLOCK_RATIO_REGS_VH
`define CORE_CLOCK_RATIO_REGS_VH

// ----------------------------------------------------------------
// Configuration codes, bit 0 of the strap is the MSB
// ----------------------------------------------------------------
`define CFG_2X_VCO2   4'h4
`define CFG_2X_VCO4   4'h5
`define CFG_2P5X      4'h6
`define CFG_3X        4'h8
`define CFG_3P5X      4'he
`define CFG_4X        4'ha
`define CFG_4P5X      4'h7
`define CFG_5X        4'hb
`define CFG_5P5X      4'h9
`define CFG_6X        4'hd
`define CFG_BYPASS    4'h3
`define CFG_CLK_OFF   4'hf

// ----------------------------------------------------------------
// Core multiplier in half units (2x -> 4)
// ----------------------------------------------------------------
`define MULT_W        4
`define HALF_1X       4'h2
`define HALF_2X       4'h4
`define HALF_2P5X     4'h5
`define HALF_3X       4'h6
`define HALF_3P5X     4'h7
`define HALF_4X       4'h8
`define HALF_4P5X     4'h9
`define HALF_5X       4'ha
`define HALF_5P5X     4'hb
`define HALF_6X       4'hc
`define VCO_NONE      3'h0
`define VCO_2X        3'h2
`define VCO_4X        3'h4

// ----------------------------------------------------------------
// Clock modes
// ----------------------------------------------------------------
`define MODE_PLL      2'h0
`define MODE_BYPASS   2'h1
`define MODE_OFF      2'h2
`define MODE_RESERVED 2'h3

`endif

/* File: hdl/ratio_code_lookup.v */
/*
 * Pure lookup from a configuration code to core multiplier, loop
 * multiplier and clock mode.
 * Assumes the caller registers the outputs.
 */
`timescale 1ns/100ps
`include "core_clock_ratio_regs.vh"

module ratio_code_lookup (
    input wire [3:0] code,
    output reg [3:0] coreHalf,
    output reg [2:0] vcoMult,
    output reg [1:0] mode
);

    always @* begin
        coreHalf = `HALF_2X;
        vcoMult = `VCO_2X;
        mode = `MODE_PLL;
        case (code)
            `CFG_2X_VCO2: coreHalf = `HALF_2X;
            `CFG_2X_VCO4: begin
                coreHalf = `HALF_2X;
                vcoMult = `VCO_4X;
            end
            `CFG_2P5X: coreHalf = `HALF_2P5X;
            `CFG_3X: coreHalf = `HALF_3X;
            `CFG_3P5X: coreHalf = `HALF_3P5X;
            `CFG_4X: coreHalf = `HALF_4X;
            `CFG_4P5X: coreHalf = `HALF_4P5X;
            `CFG_5X: coreHalf = `HALF_5X;
            `CFG_5P5X: coreHalf = `HALF_5P5X;
            `CFG_6X: coreHalf = `HALF_6X;
            `CFG_BYPASS: begin
                coreHalf = `HALF_1X;
                vcoMult = `VCO_NONE;
                mode = `MODE_BYPASS;
            end
            `CFG_CLK_OFF: begin
                coreHalf = 4'h0;
                vcoMult = `VCO_NONE;
                mode = `MODE_OFF;
            end
            default: begin
                // Undefined codes: report, keep loop quiet
                coreHalf = 4'h0;
                vcoMult = `VCO_NONE;
                mode = `MODE_RESERVED;
            end
        endcase
    end

endmodule

/* File: tb/core_clock_ratio_decoder_asserts.sv */
/* Decoder port checker; assumes straps settle before the first edge after reset. */
`timescale 1ns/100ps
module core_clock_ratio_checker(
    input wire ref_clk,
    input wire rst_b,
    input wire configValid,
    input wire loopEnable,
    input wire coreClockEnable,
    input wire bypassOneToOne,
    input wire reservedCode,
    input wire [0:3] ratioSelect,
    input wire [3:0] coreMultHalf,
    input wire [2:0] vcoMult
);
    // Own copy of the strap, taken on the decoder's capture edge,
    // so later strap changes cannot confuse the checks
    logic seen;
    logic [3:0] s;
    wire v = configValid;
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            seen <= 1'b0;
            s <= 4'h0;
        end else if (!seen) begin
            seen <= 1'b1;
            s <= ratioSelect;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_late_valid: assert property ($rose(rst_b) |-> !v ##1 !v ##1 v)
        else $error("valid");
    chk_bypass_on: assert property (v && s == 4'h3 |-> bypassOneToOne)
        else $error("bypass");
    chk_clock_off: assert property (v && s == 4'hf |-> !coreClockEnable)
        else $error("off");
    chk_vco_four: assert property (v && s == 4'h5 |-> vcoMult == 3'h4)
        else $error("vco");
    chk_half_step: assert property (v && s == 4'h9 |-> coreMultHalf == 4'hb)
        else $error("mult");
    chk_reserved_off: assert property (reservedCode |-> !coreClockEnable)
        else $error("reserved");
    chk_loop_ratio: assert property (loopEnable |-> coreMultHalf > 4'h3)
        else $error("loop");
    chk_hold_steady: assert property (v |=> $stable(coreMultHalf))
        else $error("hold");
    cover property (bypassOneToOne);
    cover property (reservedCode);
    cover property ($rose(v));
endmodule

/* File: tb/board_straps.sv */
/* Strap pin model; assumes the bench changes it at falling edges. */
`timescale 1ns/100ps
module board_straps(
    input wire [3:0] choice,
    output wire [0:3] ratioSelect
);
    assign ratioSelect = choice;
endmodule

/* File: tb/test_core_clock_ratio_decoder.sv */
/* Boots the decoder with each defined strap code and reserved code 0; assumes all modules compiled. */
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module test_core_clock_ratio_decoder;
    localparam logic [39:0] CODES = 40'h4568ea7b9d;
    logic ref_clk = 0, rst_b = 0;
    logic [3:0] choice = 4'h0;
    wire [0:3] ratioSelect;
    wire [3:0] coreMultHalf;
    wire [2:0] vcoMult;
    wire loopEnable, coreClockEnable, bypassOneToOne, reservedCode, configValid;
    wire [10:0] outs = {coreMultHalf, vcoMult, loopEnable, coreClockEnable,
        bypassOneToOne, reservedCode};
    int bad_count = 0, compares = 0;
    board_straps strap_u(
        .choice(choice),
        .ratioSelect(ratioSelect)
    );
    core_clock_ratio_decoder dut_u(
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ratioSelect(ratioSelect),
        .coreMultHalf(coreMultHalf),
        .vcoMult(vcoMult),
        .loopEnable(loopEnable),
        .coreClockEnable(coreClockEnable),
        .bypassOneToOne(bypassOneToOne),
        .reservedCode(reservedCode),
        .configValid(configValid)
    );
    initial forever #4 ref_clk = ~ref_clk;
    task finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task boot(input logic [3:0] c);
        int i;
        rst_b = 0;
        choice = c;
        repeat (3) @(negedge ref_clk);
        rst_b = 1;
        for (i = 0; i < 8 && configValid !== 1'b1; i++) @(negedge ref_clk);
        `CHK("latency", 2, i)
        if (i == 8) finish_test();
    endtask
    task test_ratios;
        for (int i = 0; i < 10; i++) begin
            boot(CODES[39 - 4 * i -: 4]);
            `CHK("mult", (i ? i + 3 : 4), coreMultHalf)
            `CHK("vco", (i == 1 ? 3'h4 : 3'h2), vcoMult)
            `CHK("flags", 4'hc, outs[3:0])
        end
    endtask
    task test_bypass;
        boot(4'h3);
        `CHK("bypass", {4'h2, 3'h0, 4'h6}, outs)
    endtask
    task test_clock_off;
        boot(4'hf);
        `CHK("clock off", 11'h0, outs)
    endtask
    task test_reserved;
        boot(4'h0);
        `CHK("reserved", 11'h1, outs)
        choice = 4'h4;
        repeat (3) @(negedge ref_clk);
        `CHK("late strap", 11'h1, outs)
    endtask
    initial begin
        test_ratios();
        test_bypass();
        test_clock_off();
        test_reserved();
        finish_test();
    end
endmodule
bind core_clock_ratio_decoder core_clock_ratio_checker chk_u(
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .configValid(configValid),
    .loopEnable(loopEnable),
    .coreClockEnable(coreClockEnable),
    .bypassOneToOne(bypassOneToOne),
    .reservedCode(reservedCode),
    .ratioSelect(ratioSelect),
    .coreMultHalf(coreMultHalf),
    .vcoMult(vcoMult)
);
